// file: inc/edfc_pkg.sv
/*
  package of the descriptor and frame configuration block: register map, field layout,
  reset values and gap offsets.
  assumes a 32-bit apb register bus; byte addresses are taken as given.
*/
package edfc_pkg;
  // register base byte addresses, each but status followed by clear/set/invert aliases
  localparam logic [7:0] ADDR_TX_DESCRIPTOR_START = 8'h00;
  localparam logic [7:0] ADDR_RX_DESCRIPTOR_START = 8'h10;
  localparam logic [7:0] ADDR_BACK_TO_BACK_GAP    = 8'h20;
  localparam logic [7:0] ADDR_MAX_FRAME_LENGTH    = 8'h30;
  localparam logic [7:0] ADDR_CONTROL             = 8'h40;
  localparam logic [7:0] ADDR_STATUS              = 8'h50;
  // alias offsets within a register slot
  localparam logic [3:0] ALIAS_WRITE = 4'h0;
  localparam logic [3:0] ALIAS_CLEAR = 4'h4;
  localparam logic [3:0] ALIAS_SET   = 4'h8;
  localparam logic [3:0] ALIAS_INV   = 4'hC;
  // field layout
  localparam int DESC_ADDR_LSB = 2;
  localparam int GAP_WIDTH     = 7;
  localparam int MAXF_WIDTH    = 16;
  localparam int CTL_FULL_DUPLEX_BIT = 0;
  // reset values
  localparam logic [31:0] RESET_DESCRIPTOR_START = 32'h0000_0000;
  localparam logic [6:0]  RESET_GAP              = 7'h12;
  localparam logic [15:0] RESET_MAX_FRAME        = 16'h05EE;
  localparam logic [31:0] RESET_CONTROL          = 32'h0000_0000;
  // enforced gap = programmed value plus duplex offset, in nibble times
  localparam logic [7:0]  GAP_OFFSET_FULL = 8'h03;
  localparam logic [7:0]  GAP_OFFSET_HALF = 8'h06;
  // apb transfer phase states
  typedef enum logic [0:0] {EDFC_IDLE, EDFC_ACCESS} edfc_state_e;
endpackage : edfc_pkg

// file: inc/edfc_gap_if.sv
/*
  interface between the register file and the gap timer.
  assumes one clock domain; the timer sees a per-nibble enable pulse.
*/
`timescale 1ns/1ps
interface edfc_gap_if;
  logic [7:0] gap_nibbles;   // enforced gap length
  logic       tx_end;        // pulse: packet ended
  logic       nibble_tick;   // pulse: one nibble time passed
  logic       gap_open;      // level: next packet may start
  modport regs  (output gap_nibbles, output tx_end, output nibble_tick, input gap_open);
  modport timer (input gap_nibbles, input tx_end, input nibble_tick, output gap_open);
endinterface : edfc_gap_if

// file: hw/edfc_gap_timer.sv
/*
  inter-packet gap timer: counts nibble times after each transmitted packet.
  assumes tx_end and nibble_tick are one-cycle pulses from the same clock.
*/
`timescale 1ns/1ps
module edfc_gap_timer (
  input  wire logic clk,
  input  wire logic reset_n,
  edfc_gap_if.timer gap
);
  logic [7:0] count_q;
  logic [7:0] count_d;

  // reload on packet end, count down on each nibble tick, holding at zero
  always_comb begin
    count_d = count_q;
    if (gap.tx_end) begin
      count_d = gap.gap_nibbles;
    end else if (gap.nibble_tick && (count_q != 8'h00)) begin
      count_d = count_q - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q <= 8'h00;
    end else begin
      count_q <= count_d;
    end
  end

  assign gap.gap_open = (count_q == 8'h00) && !gap.tx_end;
endmodule : edfc_gap_timer

// file: hw/edfc_regs.sv
/*
  descriptor start and frame configuration registers of an ethernet controller,
  with clear/set/invert aliases, an apb slave, a gap timer and a frame length check.
  assumes the transmit and receive engines supply one-cycle event pulses and a
  nibble-time enable pulse, all synchronous to clk.
*/
`timescale 1ns/1ps
module edfc_regs (
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // transmit engine
  input  wire logic        tx_done,
  input  wire logic [31:0] tx_last_descriptor,
  input  wire logic        tx_frame_end,
  input  wire logic        nibble_tick,
  output logic             tx_gap_open,
  output logic [31:0]      tx_first_descriptor_address,
  // receive engine
  input  wire logic [15:0] rx_frame_octets,
  output logic             rx_frame_too_long,
  output logic [31:0]      rx_first_descriptor_address,
  output logic [15:0]      max_frame_octets
);
  edfc_gap_if gap ();

  logic [29:0] tx_start_q, tx_start_d;
  logic [29:0] rx_start_q, rx_start_d;
  logic [6:0]  interpacket_gap_value_q, interpacket_gap_value_d;
  logic [15:0] max_frame_q, max_frame_d;
  logic        full_duplex_q, full_duplex_d;
  logic        too_long_q, too_long_d;
  logic        tx_updated_q, tx_updated_d;
  logic [31:0] prdata_q, prdata_d;

  logic        access;
  logic        wr_ok;
  logic        mapped;
  logic [7:0]  base;
  logic [3:0]  alias_sel;
  logic [31:0] wmask;

  // apb decode: slot base and alias select
  assign access    = psel && penable;
  assign base      = {paddr[7:4], 4'h0};
  assign alias_sel = paddr[3:0];
  assign mapped    = (base <= edfc_pkg::ADDR_STATUS) && (paddr[1:0] == 2'b00);
  assign wr_ok     = access && pwrite && mapped &&
                     ((pstrb == 4'hF) || (pstrb == 4'h3) || (pstrb == 4'hC));
  // per-byte write mask from the strobes of a halfword or word access
  assign wmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready    = 1'b1;
  assign pslverr   = 1'b0;
  assign prdata    = prdata_q;

  function automatic logic [31:0] apply_alias(
    input logic [31:0] cur,
    input logic [3:0]  sel,
    input logic [31:0] data,
    input logic [31:0] mask
  );
    logic [31:0] m;
    m = data & mask;
    unique case (sel)
      edfc_pkg::ALIAS_WRITE: apply_alias = (cur & ~mask) | m;
      edfc_pkg::ALIAS_CLEAR: apply_alias = cur & ~m;
      edfc_pkg::ALIAS_SET:   apply_alias = cur | m;
      edfc_pkg::ALIAS_INV:   apply_alias = cur ^ m;
      default:               apply_alias = cur;
    endcase
  endfunction : apply_alias

  // next values of the software registers and the hardware updates
  always_comb begin
    logic [31:0] tmp;
    tmp                     = 32'h0000_0000;
    tx_start_d              = tx_start_q;
    rx_start_d              = rx_start_q;
    interpacket_gap_value_d = interpacket_gap_value_q;
    max_frame_d             = max_frame_q;
    full_duplex_d           = full_duplex_q;
    tx_updated_d            = tx_updated_q;
    if (wr_ok) begin
      unique case (base)
        edfc_pkg::ADDR_TX_DESCRIPTOR_START: begin
          tmp        = apply_alias({tx_start_q, 2'b00}, alias_sel, pwdata, wmask);
          tx_start_d = tmp[31:edfc_pkg::DESC_ADDR_LSB];
        end
        edfc_pkg::ADDR_RX_DESCRIPTOR_START: begin
          tmp        = apply_alias({rx_start_q, 2'b00}, alias_sel, pwdata, wmask);
          rx_start_d = tmp[31:edfc_pkg::DESC_ADDR_LSB];
        end
        edfc_pkg::ADDR_BACK_TO_BACK_GAP: begin
          tmp = apply_alias({25'h0, interpacket_gap_value_q}, alias_sel, pwdata, wmask);
          interpacket_gap_value_d = tmp[edfc_pkg::GAP_WIDTH-1:0];
        end
        edfc_pkg::ADDR_MAX_FRAME_LENGTH: begin
          tmp         = apply_alias({16'h0, max_frame_q}, alias_sel, pwdata, wmask);
          max_frame_d = tmp[edfc_pkg::MAXF_WIDTH-1:0];
        end
        edfc_pkg::ADDR_CONTROL: begin
          tmp           = apply_alias({31'h0, full_duplex_q}, alias_sel, pwdata, wmask);
          full_duplex_d = tmp[edfc_pkg::CTL_FULL_DUPLEX_BIT];
        end
        // status: write of one clears the sticky update flag
        edfc_pkg::ADDR_STATUS: begin
          if (pwdata[0] && pstrb[0]) begin
            tx_updated_d = 1'b0;
          end
        end
        default: begin
          tmp = 32'h0000_0000;
        end
      endcase
    end
    // hardware load after success, wins over software
    // only the tx engine event touches the tx start
    if (tx_done) begin
      tx_start_d   = tx_last_descriptor[31:edfc_pkg::DESC_ADDR_LSB];
      tx_updated_d = 1'b1;
    end
  end

  // frame length check against the limit
  always_comb begin
    too_long_d = (rx_frame_octets > max_frame_q);
  end

  // read mux with unimplemented bits as zero
  always_comb begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite) begin
      prdata_d = 32'h0000_0000;
      if (paddr[3:0] == edfc_pkg::ALIAS_WRITE) begin
        unique case (base)
          edfc_pkg::ADDR_TX_DESCRIPTOR_START: prdata_d = {tx_start_q, 2'b00};
          edfc_pkg::ADDR_RX_DESCRIPTOR_START: prdata_d = {rx_start_q, 2'b00};
          edfc_pkg::ADDR_BACK_TO_BACK_GAP:    prdata_d = {25'h0, interpacket_gap_value_q};
          edfc_pkg::ADDR_MAX_FRAME_LENGTH:    prdata_d = {16'h0, max_frame_q};
          edfc_pkg::ADDR_CONTROL:             prdata_d = {31'h0, full_duplex_q};
          edfc_pkg::ADDR_STATUS:              prdata_d = {30'h0, !tx_gap_open, tx_updated_q};
          default:                            prdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  // register update
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_start_q              <= edfc_pkg::RESET_DESCRIPTOR_START[31:2];
      rx_start_q              <= edfc_pkg::RESET_DESCRIPTOR_START[31:2];
      interpacket_gap_value_q <= edfc_pkg::RESET_GAP;
      max_frame_q             <= edfc_pkg::RESET_MAX_FRAME;
      full_duplex_q           <= edfc_pkg::RESET_CONTROL[0];
      too_long_q              <= 1'b0;
      tx_updated_q            <= 1'b0;
      prdata_q                <= 32'h0000_0000;
    end else begin
      tx_start_q              <= tx_start_d;
      rx_start_q              <= rx_start_d;
      interpacket_gap_value_q <= interpacket_gap_value_d;
      max_frame_q             <= max_frame_d;
      full_duplex_q           <= full_duplex_d;
      too_long_q              <= too_long_d;
      tx_updated_q            <= tx_updated_d;
      prdata_q                <= prdata_d;
    end
  end

  // enforced gap is value plus duplex offset
  assign gap.gap_nibbles = {1'b0, interpacket_gap_value_q} +
                           (full_duplex_q ? edfc_pkg::GAP_OFFSET_FULL
                                          : edfc_pkg::GAP_OFFSET_HALF);
  assign gap.tx_end      = tx_frame_end;
  assign gap.nibble_tick = nibble_tick;

  // gap timer holds off the next packet
  edfc_gap_timer u_gap_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .gap     (gap.timer)
  );

  // outputs to the engines
  assign tx_gap_open                 = gap.gap_open;
  assign tx_first_descriptor_address = {tx_start_q, 2'b00};
  assign rx_first_descriptor_address = {rx_start_q, 2'b00};
  assign max_frame_octets            = max_frame_q;
  assign rx_frame_too_long           = too_long_q;
endmodule : edfc_regs

// file: testbench/edfc_regs_sva.sv
/*
  checker of the descriptor and frame configuration registers.
  assumes one clock, reset_n async low; watches only top-level ports.
*/
`timescale 1ns/1ps
module edfc_regs_sva (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        tx_done,
  input wire logic [31:0] tx_last_descriptor,
  input wire logic        tx_frame_end,
  input wire logic        tx_gap_open,
  input wire logic [31:0] tx_first_descriptor_address,
  input wire logic [15:0] rx_frame_octets,
  input wire logic        rx_frame_too_long,
  input wire logic [31:0] rx_first_descriptor_address,
  input wire logic [15:0] max_frame_octets
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // apb write strobe qualifier
  logic wr;
  assign wr = psel & penable & pwrite;
  property p_tx_align; tx_first_descriptor_address[1:0] == 2'h0; endproperty
  a_tx_align: assert property (p_tx_align) else $error("tx start low bits");
  property p_rx_align; rx_first_descriptor_address[1:0] == 2'h0; endproperty
  a_rx_align: assert property (p_rx_align) else $error("rx start low bits");
  property p_tx_load; tx_done |=> tx_first_descriptor_address ==
    ($past(tx_last_descriptor) & 32'hFFFF_FFFC); endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx start not loaded");
  property p_rx_keep; tx_done && !wr |=> $stable(rx_first_descriptor_address); endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx start moved on tx");
  property p_gap_hold; tx_frame_end |-> !tx_gap_open [*3]; endproperty
  a_gap_hold: assert property (p_gap_hold) else $error("gap opened early");
  property p_too_long; reset_n |=> rx_frame_too_long ==
    ($past(rx_frame_octets) > $past(max_frame_octets)); endproperty
  a_too_long: assert property (p_too_long) else $error("length check wrong");
  property p_byte_ign; wr && paddr == edfc_pkg::ADDR_MAX_FRAME_LENGTH &&
    !(pstrb inside {4'hF, 4'h3, 4'hC}) |=> $stable(max_frame_octets); endproperty
  a_byte_ign: assert property (p_byte_ign) else $error("byte write taken");
  property p_gap_upper; psel && penable && !pwrite &&
    paddr == edfc_pkg::ADDR_BACK_TO_BACK_GAP |-> prdata[31:7] == 25'h0; endproperty
  a_gap_upper: assert property (p_gap_upper) else $error("gap upper bits set");
  property p_set_alias; wr && pstrb == 4'hF && paddr == 8'h38 |=> max_frame_octets ==
    ($past(max_frame_octets) | 16'($past(pwdata))); endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias wrong");
endmodule : edfc_regs_sva
bind edfc_regs edfc_regs_sva u_sva (
  .clk                         (clk),
  .reset_n                     (reset_n),
  .psel                        (psel),
  .penable                     (penable),
  .pwrite                      (pwrite),
  .paddr                       (paddr),
  .pwdata                      (pwdata),
  .pstrb                       (pstrb),
  .prdata                      (prdata),
  .tx_done                     (tx_done),
  .tx_last_descriptor          (tx_last_descriptor),
  .tx_frame_end                (tx_frame_end),
  .tx_gap_open                 (tx_gap_open),
  .tx_first_descriptor_address (tx_first_descriptor_address),
  .rx_frame_octets             (rx_frame_octets),
  .rx_frame_too_long           (rx_frame_too_long),
  .rx_first_descriptor_address (rx_first_descriptor_address),
  .max_frame_octets            (max_frame_octets)
);

// file: testbench/edfc_regs_bench.sv
/*
  self-checking bench of the descriptor and frame configuration registers.
  assumes zero-wait apb slave and single-cycle event pulses.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module edfc_regs_bench;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, tx_done, tx_frame_end;
  logic        nibble_tick, tx_gap_open, rx_frame_too_long;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [31:0] pwdata, prdata, tx_last_descriptor, tx_first_descriptor_address;
  logic [31:0] rx_first_descriptor_address, rd;
  logic [15:0] rx_frame_octets, max_frame_octets;
  int          num_errors, check_count, n;
  edfc_regs u_dut (
    .clk                         (clk),
    .reset_n                     (reset_n),
    .psel                        (psel),
    .penable                     (penable),
    .pwrite                      (pwrite),
    .paddr                       (paddr),
    .pwdata                      (pwdata),
    .pstrb                       (pstrb),
    .pready                      (pready),
    .prdata                      (prdata),
    .pslverr                     (pslverr),
    .tx_done                     (tx_done),
    .tx_last_descriptor          (tx_last_descriptor),
    .tx_frame_end                (tx_frame_end),
    .nibble_tick                 (nibble_tick),
    .tx_gap_open                 (tx_gap_open),
    .tx_first_descriptor_address (tx_first_descriptor_address),
    .rx_frame_octets             (rx_frame_octets),
    .rx_frame_too_long           (rx_frame_too_long),
    .rx_first_descriptor_address (rx_first_descriptor_address),
    .max_frame_octets            (max_frame_octets)
  );
  // free running clock
  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end
  // one apb transfer, read data taken at the ready edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    psel    <= 0;
    penable <= 0;
  endtask : xfer
  task rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(0, a, 0, 4'hF);
    `CHK("read", e, rd)
  endtask : rchk
  // frame end, then a tick every cycle until the gap opens
  task gap_run(input int e);
    @(posedge clk) tx_frame_end <= 1;
    @(posedge clk) {tx_frame_end, nibble_tick} <= 2'b01;
    for (n = 1; n < 300; n++) begin
      @(negedge clk);
      if (tx_gap_open === 1'b1) break;
    end
    @(posedge clk) nibble_tick <= 0;
    `CHK("gap", e, n - 1)
  endtask : gap_run
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // watchdog
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
  // main sequence
  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, pstrb} = 0;
    {tx_done, tx_frame_end, nibble_tick, tx_last_descriptor} = 0;
    rx_frame_octets = 16'h05EF;
    repeat (6) @(posedge clk);
    reset_n <= 1;
    rchk(8'h00, 32'h0);
    rchk(8'h10, 32'h0);
    rchk(8'h20, 32'h12);
    rchk(8'h30, 32'h5EE);
    `CHK("long", 1'b1, rx_frame_too_long)
    xfer(1, 8'h00, 32'hFFFF_FFFF, 4'hF);
    rchk(8'h00, 32'hFFFF_FFFC);
    xfer(1, 8'h10, 32'hA5A5_A5A4, 4'hF);
    rchk(8'h10, 32'hA5A5_A5A4);
    xfer(1, 8'h20, 32'hFFFF_FFFF, 4'hF);
    rchk(8'h20, 32'h7F);
    xfer(1, 8'h30, 32'hFFFF_FFFF, 4'hF);
    rchk(8'h30, 32'hFFFF);
    xfer(1, 8'h34, 32'h00F0, 4'hF);
    rchk(8'h30, 32'hFF0F);
    xfer(1, 8'h3C, 32'hFFFF, 4'hF);
    rchk(8'h30, 32'h00F0);
    xfer(1, 8'h38, 32'h0501, 4'hF);
    rchk(8'h30, 32'h05F1);
    xfer(1, 8'h30, 32'h0, 4'h1);
    rchk(8'h30, 32'h05F1);
    xfer(1, 8'h30, 32'h05EE, 4'h3);
    rchk(8'h30, 32'h05EE);
    `CHK("slverr", 1'b0, pslverr)
    rx_frame_octets <= 16'h05EE;
    xfer(1, 8'h60, 32'h1, 4'hF);
    rchk(8'h60, 32'h0);
    `CHK("long", 1'b0, rx_frame_too_long)
    xfer(1, 8'h30, 32'h05F2, 4'h3);
    rx_frame_octets <= 16'h05F2;
    rchk(8'h30, 32'h05F2);
    `CHK("maxport", 16'h05F2, max_frame_octets)
    `CHK("long", 1'b0, rx_frame_too_long)
    @(posedge clk) {tx_done, tx_last_descriptor} <= {1'b1, 32'h1234_5677};
    @(posedge clk) tx_done <= 0;
    @(negedge clk);
    `CHK("txport", 32'h1234_5674, tx_first_descriptor_address)
    `CHK("rxport", 32'hA5A5_A5A4, rx_first_descriptor_address)
    rchk(8'h00, 32'h1234_5674);
    rchk(8'h50, 32'h1);
    xfer(1, 8'h50, 32'h1, 4'hF);
    rchk(8'h50, 32'h0);
    xfer(1, 8'h40, 32'h1, 4'hF);
    xfer(1, 8'h20, 32'h15, 4'hF);
    gap_run(24);
    xfer(1, 8'h40, 32'h0, 4'hF);
    xfer(1, 8'h20, 32'h12, 4'hF);
    gap_run(24);
    report_and_stop;
  end
endmodule : edfc_regs_bench
